// ==== frw_consts.vh ====
// constants for the flash register write and protection block
// Notes on behaviour
// - area side bit is one-time, top at 0
// - area side changes only by register write
// - setup register: dummy bit6, side bit3, drive bit0
// - dummy counts: dual 4/8, quad 6-8/10
// - register write updates status register, and setup register only when a third byte is sent
// - write sets lock, quad, protect; not latch/busy
// - register write refused in hard protect state
// - select must rise on byte boundary
// - timed write cycle starts at select rising
// - busy high during cycle, then latch cleared
// - hard protect when lock set and guard low
// - hard protect freezes lock, protect, side bits
// - soft protect otherwise; bits stay writable
// - protected region blocks program and erase
// - hard protect left only by guard high; the code also leaves it when a write begun before guard fell sets quad
// - four-I/O mode disables hard protect
// - quad bit bit6 turns guard pin into data
// - refused program/erase clears write latch
`ifndef FRW_CONSTS_VH
`define FRW_CONSTS_VH
// command opcodes
`define FRW_OP_WRITE_REGS 8'h01
`define FRW_OP_WRITE_DIS  8'h04
`define FRW_OP_READ_STAT  8'h05
`define FRW_OP_WRITE_EN   8'h06
`define FRW_OP_READ_SETUP 8'h15
// status register field positions
`define FRW_ST_LOCK       7
`define FRW_ST_QUAD       6
`define FRW_ST_PROT_HI    5
`define FRW_ST_PROT_LO    2
`define FRW_ST_LATCH      1
`define FRW_ST_BUSY       0
// setup register field positions
`define FRW_CF_DUMMY      6
`define FRW_CF_SIDE       3
`define FRW_CF_DRIVE      0
// reset values
`define FRW_PROT_RESET    4'h0
// dummy cycle counts
`define FRW_DUAL_DUMMY_LO 4'h4
`define FRW_DUAL_DUMMY_HI 4'h8
`define FRW_QUAD_DUMMY_SL 4'h6
`define FRW_QUAD_DUMMY_FS 4'h8
`define FRW_QUAD_DUMMY_HI 4'hA
// timing
`define FRW_CLK_PERIOD_NS 10
`define FRW_WRITE_TIME_NS 1000000
`define FRW_WRITE_CYCLES  (`FRW_WRITE_TIME_NS / `FRW_CLK_PERIOD_NS)
`endif

// ==== frw_host_model.sv ====
// host side model of the serial link that shifts frames and captures read-back
`timescale 1ns/10ps
`default_nettype none
module frw_host_model
(
  // link pins
  output logic        serial_clock,
  output logic        chip_select_n,
  output logic        serial_in,
  input  wire logic   serial_out,
  // captured read-back bits
  output logic [23:0] rx
);
  // link clock stands still low between frames
  initial
  begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    rx = 24'h0;
  end
  // select low, n bits msb first from the top of d, then select high
  task frame(input logic [23:0] d, input integer n);
    integer i;
    begin
      chip_select_n = 1'b0;
      #40;
      for (i = 0; i < n; i = i + 1)
      begin
        serial_in = d[23 - i];
        #40;
        serial_clock = 1'b1;
        rx = {rx[22:0], serial_out};
        #40;
        serial_clock = 1'b0;
      end
      serial_in = ~serial_in; // a released line must not keep showing the last bit
      #40;
      chip_select_n = 1'b1;
      #80;
    end
  endtask
endmodule
`default_nettype wire

// ==== frw_reg_protect.v ====
// register write cycle and write protection logic of a serial flash
`timescale 1ns/10ps
`default_nettype none
`include "frw_consts.vh"
module frw_reg_protect
#(
  parameter integer WRITE_CYCLES = `FRW_WRITE_CYCLES
)
(
  // clock and reset
  input  wire       clock,
  input  wire       sys_rst,
  // serial link pins
  input  wire       serial_clock,
  input  wire       chip_select_n,
  input  wire       serial_in,
  input  wire       write_guard_pin,
  output reg        serial_out,
  output reg        serial_out_en,
  // program and erase gate, and frequency range for quad dummy cycles
  input  wire       pe_request,
  input  wire       pe_target_protected,
  input  wire       freq_range_high,
  output reg        pe_grant,
  output reg        pe_refused,
  // state shown to the array logic
  output reg        write_busy_flag,
  output reg        write_latch_flag,
  output reg        hard_protect_state,
  output reg  [3:0] protect_level_bits,
  output reg        area_side_select,
  output reg        quad_enable_bit,
  output reg        drive_strength_select,
  output reg  [3:0] dual_dummy_cycles,
  output reg  [3:0] quad_dummy_cycles
);

  // write cycle states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  // pin synchronisers: stage one feeds stage two only
  wire [3:0] pin_raw;
  reg  [3:0] pin_s1;
  reg  [3:0] pin_s2;
  reg        sclk_prev;
  reg        cs_prev;
  assign pin_raw = {write_guard_pin, serial_in, chip_select_n, serial_clock};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      always @(posedge clock)
      begin
        if (sys_rst)
        begin
          pin_s1[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          pin_s2[gi] <= (gi == 1) ? 1'b1 : 1'b0;
        end
        else
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  wire sclk_s  = pin_s2[0];
  wire cs_n_s  = pin_s2[1];
  wire si_s    = pin_s2[2];
  wire guard_s = pin_s2[3];

  wire sclk_rise = sclk_s & ~sclk_prev;
  wire sclk_fall = ~sclk_s & sclk_prev;
  wire cs_rise   = cs_n_s & ~cs_prev;

  // frame ended on a byte boundary with the given byte count
  function frame_ok;
    input [2:0] bits;
    input [1:0] bytes;
    input [1:0] need;
    begin
      frame_ok = (bits == 3'h0) && (bytes == need);
    end
  endfunction

  // frame state
  reg [7:0] shift_in;
  reg [2:0] bit_cnt;
  reg [1:0] byte_cnt;
  reg [7:0] opcode;
  reg [7:0] stat_byte;
  reg [7:0] setup_byte;
  reg [7:0] shift_out;
  reg       reading;

  // setup register storage, reserved bits kept as written
  reg [7:0] setup_reg;
  reg       dummy_sel;

  // write cycle state
  reg [1:0]  state;
  reg [31:0] wait_cnt;
  reg [7:0]  pend_stat;
  reg [7:0]  pend_setup;
  reg        pend_has_setup;

  reg protect_lock;

  // guard pin acts as data in four-I/O mode, so it cannot protect
  wire hard_now = quad_enable_bit ? 1'b0 : (protect_lock & ~guard_s);

  // status and setup words as read back over the link
  wire [7:0] stat_word = {protect_lock, quad_enable_bit, protect_level_bits,
                          write_latch_flag, write_busy_flag};
  wire [7:0] setup_word = {setup_reg[7], dummy_sel, setup_reg[5:4], area_side_select,
                           setup_reg[2:1], drive_strength_select};

  wire [7:0] next_shift_in = {shift_in[6:0], si_s};
  wire       byte_done     = sclk_rise & ~cs_n_s & (bit_cnt == 3'h7);

  // commands judged at the end of the frame
  wire cmd_lset = cs_rise & (opcode == `FRW_OP_WRITE_EN)
                  & frame_ok(bit_cnt, byte_cnt, 2'h1);
  wire cmd_lclr = cs_rise & (opcode == `FRW_OP_WRITE_DIS)
                  & frame_ok(bit_cnt, byte_cnt, 2'h1);
  wire cmd_regw = cs_rise & (opcode == `FRW_OP_WRITE_REGS)
                  & (frame_ok(bit_cnt, byte_cnt, 2'h2)
                     | frame_ok(bit_cnt, byte_cnt, 2'h3))
                  & write_latch_flag
                  & ~hard_now
                  & (state == ST_IDLE);
  wire write_done = (state == ST_BUSY) & (wait_cnt == 32'h0000_0000);

  // edge history of link clock and select
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;
    end
    else
    begin
      sclk_prev <= sclk_s;
      cs_prev   <= cs_n_s;
    end
  end

  // command shifter: counts bits and bytes within a frame
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      shift_in   <= 8'h00;
      bit_cnt    <= 3'h0;
      byte_cnt   <= 2'h0;
      opcode     <= 8'h00;
      stat_byte  <= 8'h00;
      setup_byte <= 8'h00;
    end
    else if (cs_n_s)
    begin
      bit_cnt  <= 3'h0;
      if (!cs_rise)
        byte_cnt <= 2'h0;
    end
    else if (sclk_rise)
    begin
      shift_in <= next_shift_in;
      bit_cnt  <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7)
      begin
        // count saturates so over-long frames read as byte three
        if (byte_cnt != 2'h3)
          byte_cnt <= byte_cnt + 2'h1;
        case (byte_cnt)
          2'h0: opcode <= next_shift_in;
          2'h1: stat_byte <= next_shift_in;
          2'h2: setup_byte <= next_shift_in;
          default: ;
        endcase
      end
    end
  end

  // read-back shifter: bits leave on falling link clock edges
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      shift_out     <= 8'h00;
      reading       <= 1'b0;
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else if (cs_n_s)
    begin
      reading       <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else if (byte_done && (byte_cnt == 2'h0 || reading))
    begin
      // the status read repeats so busy can be polled in one frame
      if ((byte_cnt == 2'h0 ? next_shift_in : opcode) == `FRW_OP_READ_STAT)
      begin
        reading   <= 1'b1;
        shift_out <= stat_word;
      end
      else if ((byte_cnt == 2'h0 ? next_shift_in : opcode) == `FRW_OP_READ_SETUP)
      begin
        reading   <= 1'b1;
        shift_out <= setup_word;
      end
    end
    else if (sclk_fall && reading)
    begin
      serial_out    <= shift_out[7];
      serial_out_en <= 1'b1;
      shift_out     <= {shift_out[6:0], 1'b0};
    end
  end

  // self-timed register write cycle
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      state          <= ST_IDLE;
      wait_cnt       <= 32'h0000_0000;
      pend_stat      <= 8'h00;
      pend_setup     <= 8'h00;
      pend_has_setup <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (cmd_regw)
          begin
            state          <= ST_BUSY;
            wait_cnt       <= WRITE_CYCLES - 1;
            pend_stat      <= stat_byte;
            pend_setup     <= setup_byte;
            pend_has_setup <= (byte_cnt == 2'h3);
          end
        end
        ST_BUSY:
        begin
          if (wait_cnt == 32'h0000_0000)
            state <= ST_IDLE;
          else
            wait_cnt <= wait_cnt - 32'h0000_0001;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // register contents, written only at the end of a write cycle
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      protect_lock          <= 1'b0;
      quad_enable_bit       <= 1'b0;
      protect_level_bits    <= `FRW_PROT_RESET;
      area_side_select      <= 1'b0;
      setup_reg             <= 8'h00;
      dummy_sel             <= 1'b0;
      drive_strength_select <= 1'b0;
    end
    else if (write_done)
    begin
      quad_enable_bit <= pend_stat[`FRW_ST_QUAD];
      // guard may have fallen during the cycle; frozen bits stay put
      if (!hard_now)
      begin
        protect_lock       <= pend_stat[`FRW_ST_LOCK];
        protect_level_bits <= pend_stat[`FRW_ST_PROT_HI:`FRW_ST_PROT_LO];
      end
      if (pend_has_setup)
      begin
        setup_reg             <= pend_setup;
        dummy_sel             <= pend_setup[`FRW_CF_DUMMY];
        drive_strength_select <= pend_setup[`FRW_CF_DRIVE];
        // one-time bit: can be set, never cleared again
        if (!hard_now)
          area_side_select <= area_side_select | pend_setup[`FRW_CF_SIDE];
      end
    end
  end

  // write latch and busy flag
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      write_latch_flag <= 1'b0;
      write_busy_flag  <= 1'b0;
    end
    else
    begin
      write_busy_flag <= (state == ST_BUSY) & ~write_done;
      // a set arriving with a clear wins, but only when no write cycle is running
      if (cmd_lset && state == ST_IDLE)
        write_latch_flag <= 1'b1;
      else if (write_done || cmd_lclr || pe_refused)
        write_latch_flag <= 1'b0;
    end
  end

  // protection state and dummy cycle selection
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      hard_protect_state <= 1'b0;
      dual_dummy_cycles  <= `FRW_DUAL_DUMMY_LO;
      quad_dummy_cycles  <= `FRW_QUAD_DUMMY_SL;
    end
    else
    begin
      hard_protect_state <= hard_now;
      dual_dummy_cycles  <= dummy_sel ? `FRW_DUAL_DUMMY_HI : `FRW_DUAL_DUMMY_LO;
      if (dummy_sel)
        quad_dummy_cycles <= `FRW_QUAD_DUMMY_HI;
      else
        quad_dummy_cycles <= freq_range_high ? `FRW_QUAD_DUMMY_FS : `FRW_QUAD_DUMMY_SL;
    end
  end

  // program and erase gate; the array decodes region from level and side
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      pe_grant   <= 1'b0;
      pe_refused <= 1'b0;
    end
    else
    begin
      pe_grant   <= pe_request & write_latch_flag & ~pe_target_protected
                    & (state == ST_IDLE);
      pe_refused <= pe_request & pe_target_protected;
    end
  end

endmodule
`default_nettype wire

// ==== frw_reg_protect_properties.sv ====
// concurrent checks on the register write and protection ports
`timescale 1ns/10ps
`default_nettype none
module frw_reg_protect_properties
#(
  parameter integer WRITE_CYCLES = 20
)
(
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // program and erase gate
  input wire logic       pe_request,
  input wire logic       pe_target_protected,
  input wire logic       pe_grant,
  input wire logic       pe_refused,
  // register state
  input wire logic       write_busy_flag,
  input wire logic       write_latch_flag,
  input wire logic       hard_protect_state,
  input wire logic [3:0] protect_level_bits,
  input wire logic       area_side_select,
  input wire logic       quad_enable_bit
);
  logic [15:0] busy_cnt;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // counter of busy cycles, so a long write needs no long repetition
  always @(posedge clock)
    busy_cnt <= (sys_rst || !write_busy_flag) ? 16'h0 : busy_cnt + 16'h1;
  busy_len_a: assert property ($fell(write_busy_flag) |-> busy_cnt == WRITE_CYCLES - 1)
    else $error("write cycle length wrong");
  latch_clear_a: assert property ($fell(write_busy_flag) |-> !write_latch_flag)
    else $error("latch not cleared at write end");
  latch_needed_a: assert property ($rose(write_busy_flag) |-> $past(write_latch_flag))
    else $error("write started without latch");
  hard_refuse_a: assert property ($rose(write_busy_flag) |-> !$past(hard_protect_state))
    else $error("write started in hard protect");
  hard_freeze_a: assert property (hard_protect_state |=> $stable(protect_level_bits)
    && $stable(area_side_select)) else $error("frozen bits changed");
  side_once_a: assert property ($past(area_side_select) |-> area_side_select)
    else $error("area side bit cleared");
  quad_nohard_a: assert property (quad_enable_bit && $past(quad_enable_bit) |-> !hard_protect_state)
    else $error("hard protect in quad mode");
  pe_block_a: assert property (pe_request && pe_target_protected |=> pe_refused && !pe_grant)
    else $error("protected target not refused");
  refuse_latch_a: assert property (pe_refused |=> !write_latch_flag)
    else $error("latch kept after refusal");
endmodule
bind frw_reg_protect frw_reg_protect_properties #(.WRITE_CYCLES(WRITE_CYCLES)) chk
  (.clock(clock), .sys_rst(sys_rst), .pe_request(pe_request),
   .pe_target_protected(pe_target_protected), .pe_grant(pe_grant), .pe_refused(pe_refused),
   .write_busy_flag(write_busy_flag), .write_latch_flag(write_latch_flag),
   .hard_protect_state(hard_protect_state), .protect_level_bits(protect_level_bits),
   .area_side_select(area_side_select), .quad_enable_bit(quad_enable_bit));
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the register write and protection block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam integer WC = 20;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        write_guard_pin = 1'b1;
  logic        pe_request = 1'b0;
  logic        pe_target_protected = 1'b0;
  logic        freq_range_high = 1'b0;
  wire         serial_clock, chip_select_n, serial_in, serial_out, serial_out_en, pe_grant;
  wire         pe_refused, write_busy_flag, write_latch_flag, hard_protect_state;
  wire         area_side_select, quad_enable_bit, drive_strength_select;
  wire [3:0]   protect_level_bits, dual_dummy_cycles, quad_dummy_cycles;
  wire [23:0]  rx;
  integer      mismatches = 0;
  integer      n_tests = 0;
  integer      cyc = 0;
  integer      en_cnt = 0;
  logic [31:0] seed = 32'h61;
  logic [7:0]  expq [$];
  event        seen;
  always #5 clock = ~clock;
  frw_host_model host (.serial_clock(serial_clock), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .rx(rx));
  frw_reg_protect #(.WRITE_CYCLES(WC)) uut (.clock(clock), .sys_rst(sys_rst),
    .serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .write_guard_pin(write_guard_pin), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .pe_request(pe_request), .pe_target_protected(pe_target_protected),
    .freq_range_high(freq_range_high), .pe_grant(pe_grant), .pe_refused(pe_refused),
    .write_busy_flag(write_busy_flag), .write_latch_flag(write_latch_flag),
    .hard_protect_state(hard_protect_state), .protect_level_bits(protect_level_bits),
    .area_side_select(area_side_select), .quad_enable_bit(quad_enable_bit),
    .drive_strength_select(drive_strength_select), .dual_dummy_cycles(dual_dummy_cycles),
    .quad_dummy_cycles(quad_dummy_cycles));
  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task check(input logic [7:0] got, input logic [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // watcher: each captured read byte is matched with the oldest note
  always @(seen)
    check(rx[7:0], expq.pop_front());
  // the read byte follows the opcode, so the last eight captured bits hold it
  // the output enable must have risen during the read and dropped after it
  task rd(input logic [7:0] op, input logic [7:0] exp);
    integer e0;
    begin
      e0 = en_cnt;
      expq.push_back(exp);
      host.frame({op, 16'h0}, 16);
      -> seen;
      check({6'h0, serial_out_en, en_cnt > e0}, 8'h01);
    end
  endtask
  // waits out the longest possible write so the next frame never meets busy
  task wr(input logic [23:0] d, input integer n);
    begin
      host.frame(d, n);
      repeat (WC + 6) @(posedge clock);
      #1;
    end
  endtask
  task pe(input logic p, input logic [7:0] exp);
    begin
      pe_request = 1'b1;
      pe_target_protected = p;
      @(posedge clock);
      #1;
      pe_request = 1'b0;
      check({6'h0, pe_grant, pe_refused}, exp);
      @(posedge clock);
      #1;
    end
  endtask
  task settle;
    begin
      repeat (4) @(posedge clock);
      #1;
    end
  endtask
  // hang guard well above the few thousand cycles the sequence needs
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (serial_out_en === 1'b1)
      en_cnt = en_cnt + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  initial
  begin
    repeat (6) @(posedge clock);
    #1 sys_rst = 1'b0;
    seed = xs(seed);
    freq_range_high = seed[0];
    settle;
    check({dual_dummy_cycles, quad_dummy_cycles}, seed[0] ? 8'h48 : 8'h46);
    rd(8'h05, 8'h00);
    rd(8'h15, 8'h00);
    wr({8'h01, 8'h3C, 8'h00}, 16);
    rd(8'h05, 8'h00);
    $display("test reset and unlatched write done");
    wr({8'h06, 16'h0}, 8);
    rd(8'h05, 8'h02);
    host.frame({8'h01, 8'hBF, 8'h49}, 24);
    check({7'h0, write_busy_flag}, 8'h01);
    repeat (WC) @(posedge clock);
    #1;
    check({dual_dummy_cycles, quad_dummy_cycles}, 8'h8A);
    check({protect_level_bits, area_side_select, drive_strength_select,
      write_busy_flag, write_latch_flag}, 8'hFC);
    rd(8'h05, 8'hBC);
    rd(8'h15, 8'h49);
    $display("test full register write done");
    write_guard_pin = 1'b0;
    settle;
    check({7'h0, hard_protect_state}, 8'h01);
    wr({8'h06, 16'h0}, 8);
    wr({8'h01, 8'h00, 8'h00}, 24);
    rd(8'h05, 8'hBE);
    rd(8'h15, 8'h49);
    write_guard_pin = 1'b1;
    settle;
    check({7'h0, hard_protect_state}, 8'h00);
    wr({8'h06, 16'h0}, 8);
    wr({8'h01, 8'hC0, 8'h00}, 16);
    rd(8'h05, 8'hC0);
    rd(8'h15, 8'h49);
    write_guard_pin = 1'b0;
    settle;
    check({7'h0, hard_protect_state}, 8'h00);
    $display("test protection modes done");
    wr({8'h06, 16'h0}, 8);
    wr({8'h01, 8'h00, 8'h00}, 15);
    rd(8'h05, 8'hC2);
    pe(1'b1, 8'h01);
    rd(8'h05, 8'hC0);
    pe(1'b0, 8'h00);
    wr({8'h06, 16'h0}, 8);
    pe(1'b0, 8'h02);
    $display("test boundary and program gate done");
    finish_test;
  end
endmodule
`default_nettype wire
